/* File: core/windowed_watchdog_reset_supervisor.sv */
// Windowed watchdog with fault pulse output and stretched reset generator.
//
// Behaviour
// - Operator reset low forces reset, clears window timer, releases fault pulse.
// - Operator reset low cuts off any fault pulse in progress.
// - Reset asserts while supply is below trip level or operator reset is low.
// - Reset holds at least 100 ms after supply good and operator reset high.
// - Window timer clears on each accepted kick fall and when reset releases.
// - Window timer clears when the fault pulse ends, starting a new window.
// - A kick fall between early and late limits raises no fault.
// - A kick fall before the early limit raises a fast fault.
// - No kick fall before the late limit raises a slow fault.
// - Any fault drives the fault pulse low for nominally 1 ms.
// - The fault pulse can only assert while reset is inactive.
// - Kick edges are ignored while reset or the fault pulse is active.
// - First kick fall after reset or fault pulse never counts as fast.
// - A watchdog fault never asserts reset by itself.
// - Operator reset glitches of about 100 ns are rejected.
// - Kick pulses of 300 ns or more are always recognised.
`timescale 1ns/1ps
module windowed_watchdog_reset_supervisor #(
  parameter int unsigned RESET_STRETCH_TICKS = supervisor_pkg::RESET_STRETCH_TICKS,
  parameter int unsigned EARLY_LIMIT_TICKS   = supervisor_pkg::EARLY_LIMIT_TICKS,
  parameter int unsigned LATE_LIMIT_TICKS    = supervisor_pkg::LATE_LIMIT_TICKS,
  parameter int unsigned FAULT_PULSE_TICKS   = supervisor_pkg::FAULT_PULSE_TICKS
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Supervised inputs
  input  wire logic operator_reset_n_in,
  input  wire logic supply_good_in,
  input  wire logic kick_input_in,
  // Reset output, active low, push-pull
  output logic      reset_n_out,
  // Open-drain fault pulse: level driven and its enable
  output logic      fault_pulse_out,
  output logic      fault_pulse_oe_out,
  // Fault reports, one cycle each
  output logic      fast_fault_out,
  output logic      slow_fault_out
);

  localparam int unsigned W = supervisor_pkg::TIMER_W;

  localparam logic [W-1:0] EARLY_C  = W'(EARLY_LIMIT_TICKS);
  localparam logic [W-1:0] LATE_C   = W'(LATE_LIMIT_TICKS);
  localparam logic [W-1:0] PULSE_C  = W'(FAULT_PULSE_TICKS - 1);
  localparam logic [W-1:0] ONE_C    = W'(1);
  localparam logic [supervisor_pkg::PRESC_W-1:0] PRESC_END_C =
    supervisor_pkg::PRESC_W'(supervisor_pkg::TICK_CYCLES - 1);
  localparam logic [supervisor_pkg::PRESC_W-1:0] PRESC_ONE_C =
    supervisor_pkg::PRESC_W'(1);

  // Counts up by one tick and stops at the top instead of wrapping.
  function automatic logic [W-1:0] sat_inc(input logic [W-1:0] value);
    sat_inc = (&value) ? value : value + ONE_C;
  endfunction : sat_inc

  filt_if oper_sig ();
  filt_if supply_sig ();
  filt_if kick_sig ();

  logic                               tick_q;
  logic [supervisor_pkg::PRESC_W-1:0] presc_q;
  logic                               reset_active;
  logic                               hold_req;
  logic                               wd_hold;
  supervisor_pkg::wd_state_e          state_q;
  logic [W-1:0]                       window_q;
  logic [W-1:0]                       pulse_cnt_q;
  logic                               first_q;
  logic                               holding;
  logic                               watching;
  logic                               pulsing;
  logic                               kick_seen;
  logic                               fast_hit;
  logic                               kick_ok;
  logic                               slow_hit;
  logic                               pulse_done;

  // ==========================================================================
  // Input qualification
  // ==========================================================================
  // glitch rejection
  input_filter #(
    .STABLE_CYCLES (supervisor_pkg::OPER_FILTER_CYCLES),
    .RESET_LEVEL   (supervisor_pkg::LEVEL_HIGH)
  ) u_oper_filter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .raw_in      (operator_reset_n_in),
    .sig         (oper_sig)
  );

  input_filter #(
    .STABLE_CYCLES (supervisor_pkg::SUPPLY_FILTER_CYCLES),
    .RESET_LEVEL   (supervisor_pkg::LEVEL_LOW)
  ) u_supply_filter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .raw_in      (supply_good_in),
    .sig         (supply_sig)
  );

  input_filter #(
    .STABLE_CYCLES (supervisor_pkg::KICK_FILTER_CYCLES),
    .RESET_LEVEL   (supervisor_pkg::LEVEL_HIGH)
  ) u_kick_filter (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .raw_in      (kick_input_in),
    .sig         (kick_sig)
  );

  // ==========================================================================
  // Reference tick
  // ==========================================================================
  // free-running tick
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_q <= '0;
      tick_q  <= 1'b0;
    end else if (presc_q == PRESC_END_C) begin
      presc_q <= '0;
      tick_q  <= 1'b1;
    end else begin
      presc_q <= presc_q + PRESC_ONE_C;
      tick_q  <= 1'b0;
    end
  end

  // ==========================================================================
  // Reset generation
  // ==========================================================================
  // supply or operator hold
  assign hold_req = ~oper_sig.level | ~supply_sig.level;

  reset_stretcher #(
    .STRETCH_TICKS (RESET_STRETCH_TICKS)
  ) u_stretcher (
    .core_clk_in      (core_clk_in),
    .rst_in           (rst_in),
    .tick_in          (tick_q),
    .hold_in          (hold_req),
    .reset_active_out (reset_active)
  );

  // The watchdog also looks at the raw hold so an operator reset acts
  // without waiting for the stretcher's own register.
  assign wd_hold = hold_req | reset_active;

  // ==========================================================================
  // Window watchdog
  // ==========================================================================
  // Each register below has its own process; these decodes tie them together.
  assign holding  = (state_q == supervisor_pkg::ST_HOLD);
  assign watching = (state_q == supervisor_pkg::ST_WATCH) & ~wd_hold;
  assign pulsing  = (state_q == supervisor_pkg::ST_PULSE) & ~wd_hold;

  // A kick that falls as the late limit is reached is already too late.
  assign kick_seen = watching & kick_sig.fell & (window_q < LATE_C);

  assign fast_hit = kick_seen & ~first_q & (window_q < EARLY_C);

  assign kick_ok = kick_seen & ~fast_hit;

  assign slow_hit = watching & (window_q >= LATE_C);

  assign pulse_done = pulsing & tick_q & (pulse_cnt_q >= PULSE_C);

  // ==========================================================================
  // Watchdog state
  // ==========================================================================
  // faults only steer the pulse, never the stretcher
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= supervisor_pkg::ST_HOLD;
    end else begin
      unique case (state_q)
        supervisor_pkg::ST_HOLD: begin
          if (!wd_hold) begin
            state_q <= supervisor_pkg::ST_WATCH;
          end
        end
        supervisor_pkg::ST_WATCH: begin
          if (wd_hold) begin
            state_q <= supervisor_pkg::ST_HOLD;
          end else if (fast_hit || slow_hit) begin
            state_q <= supervisor_pkg::ST_PULSE;
          end
        end
        supervisor_pkg::ST_PULSE: begin
          if (wd_hold) begin
            state_q <= supervisor_pkg::ST_HOLD;
          end else if (pulse_done) begin
            state_q <= supervisor_pkg::ST_WATCH;
          end
        end
        default: begin
          state_q <= supervisor_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // ==========================================================================
  // Window timer
  // ==========================================================================
  // timer held at zero
  // clear on reset release and accepted kick
  // new window after pulse
  // The timer stands still through a pulse and is cleared as the pulse ends.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      window_q <= '0;
    end else if (holding || kick_ok || pulse_done) begin
      window_q <= '0;
    end else if (watching && !kick_seen && !slow_hit && tick_q) begin
      window_q <= sat_inc(window_q);
    end
  end

  // ==========================================================================
  // Pulse counter
  // ==========================================================================
  // The first tick of a pulse may come at once, so the pulse is one tick short at worst.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_cnt_q <= '0;
    end else if (holding || fast_hit || slow_hit) begin
      pulse_cnt_q <= '0;
    end else if (pulsing && tick_q && !pulse_done) begin
      pulse_cnt_q <= sat_inc(pulse_cnt_q);
    end
  end

  // ==========================================================================
  // First kick flag
  // ==========================================================================
  // first kick exempt
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_q <= 1'h1;
    end else if (holding || pulse_done) begin
      first_q <= 1'h1;
    end else if (kick_ok) begin
      first_q <= 1'h0;
    end
  end

  // ==========================================================================
  // Fault reports
  // ==========================================================================
  // One-cycle reports let a host or a counter tell the two faults apart.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_fault_out <= 1'h0;
      slow_fault_out <= 1'h0;
    end else begin
      fast_fault_out <= fast_hit;
      slow_fault_out <= slow_hit;
    end
  end

  // ==========================================================================
  // Output stage
  // ==========================================================================
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_n_out <= 1'b0;
    end else begin
      reset_n_out <= ~reset_active;
    end
  end

  // The open-drain pin only ever pulls low; the enable carries the pulse.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_pulse_out    <= 1'b0;
      fault_pulse_oe_out <= 1'b0;
    end else begin
      fault_pulse_out    <= 1'b0;
      fault_pulse_oe_out <= pulsing;
    end
  end

endmodule : windowed_watchdog_reset_supervisor

/* File: core/supervisor_pkg.sv */
// Shared constants, timing figures and state encoding of the supervisor.
package supervisor_pkg;

  // ==========================================================================
  // Clock and reference tick
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W       = 7;
  localparam int unsigned TIMER_W       = 24;
  localparam int unsigned FILT_CNT_W    = 6;

  // ==========================================================================
  // Input qualification times
  // ==========================================================================
  // The operator input must stay low for longer than a glitch, so round up past it.
  localparam int unsigned OPER_GLITCH_NS       = 100;
  localparam int unsigned OPER_FILTER_CYCLES   = OPER_GLITCH_NS / CLK_PERIOD_NS + 1;
  // A kick pulse of the minimum width must still pass, so round down.
  localparam int unsigned KICK_MIN_PULSE_NS    = 300;
  localparam int unsigned KICK_FILTER_CYCLES   = KICK_MIN_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned SUPPLY_FILTER_CYCLES = 1;

  // ==========================================================================
  // Supervisor times, counted in reference ticks
  // ==========================================================================
  localparam int unsigned NS_PER_MS           = 1000000;
  localparam int unsigned NS_PER_US           = 1000;
  localparam int unsigned RESET_STRETCH_MS    = 100;
  localparam int unsigned FAULT_PULSE_MS      = 1;
  localparam int unsigned EARLY_LIMIT_US      = 1000;
  localparam int unsigned LATE_LIMIT_US       = 10000;
  localparam int unsigned RESET_STRETCH_TICKS = RESET_STRETCH_MS * (NS_PER_MS / TICK_NS);
  localparam int unsigned FAULT_PULSE_TICKS   = FAULT_PULSE_MS * (NS_PER_MS / TICK_NS);
  localparam int unsigned EARLY_LIMIT_TICKS   = EARLY_LIMIT_US * NS_PER_US / TICK_NS;
  localparam int unsigned LATE_LIMIT_TICKS    = LATE_LIMIT_US * NS_PER_US / TICK_NS;

  // ==========================================================================
  // Reset levels and watchdog states
  // ==========================================================================
  localparam logic LEVEL_HIGH = 1'b1;
  localparam logic LEVEL_LOW  = 1'b0;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h1,
    ST_WATCH = 3'h2,
    ST_PULSE = 3'h4
  } wd_state_e;

endpackage : supervisor_pkg

/* File: core/filt_if.sv */
// Qualified level and falling-edge event of one filtered input.
`timescale 1ns/1ps
interface filt_if;
  logic level;
  logic fell;

  modport src (output level, output fell);
  modport dst (input level, input fell);
endinterface : filt_if

/* File: core/input_filter.sv */
// Two-stage synchroniser followed by a stability filter for one input.
`timescale 1ns/1ps
module input_filter #(
  parameter int unsigned STABLE_CYCLES = 1,
  parameter logic        RESET_LEVEL   = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Raw input
  input  wire logic raw_in,
  // Qualified result
  filt_if.src       sig
);

  localparam logic [supervisor_pkg::FILT_CNT_W-1:0] LIMIT_C =
    supervisor_pkg::FILT_CNT_W'(STABLE_CYCLES - 1);
  localparam logic [supervisor_pkg::FILT_CNT_W-1:0] ONE_C =
    supervisor_pkg::FILT_CNT_W'(1);

  logic                                  sync1_q;
  logic                                  sync2_q;
  logic                                  level_q;
  logic                                  fell_q;
  logic [supervisor_pkg::FILT_CNT_W-1:0] cnt_q;

  // ==========================================================================
  // Synchroniser
  // ==========================================================================
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= RESET_LEVEL;
      sync2_q <= RESET_LEVEL;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // Stability filter
  // ==========================================================================
  // A change is taken only after it has held for STABLE_CYCLES clocks in a row.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q   <= '0;
      level_q <= RESET_LEVEL;
      fell_q  <= 1'b0;
    end else if (sync2_q == level_q) begin
      cnt_q  <= '0;
      fell_q <= 1'b0;
    end else if (cnt_q == LIMIT_C) begin
      cnt_q   <= '0;
      level_q <= sync2_q;
      fell_q  <= ~sync2_q;
    end else begin
      cnt_q  <= cnt_q + ONE_C;
      fell_q <= 1'b0;
    end
  end

  assign sig.level = level_q;
  assign sig.fell  = fell_q;

endmodule : input_filter

/* File: core/reset_stretcher.sv */
// Holds reset while a hold request stands and stretches its release by a tick count.
`timescale 1ns/1ps
module reset_stretcher #(
  parameter int unsigned STRETCH_TICKS = supervisor_pkg::RESET_STRETCH_TICKS
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // Controls
  input  wire logic tick_in,
  input  wire logic hold_in,
  // Result
  output logic      reset_active_out
);

  localparam logic [supervisor_pkg::TIMER_W-1:0] STRETCH_C = supervisor_pkg::TIMER_W'(STRETCH_TICKS);
  localparam logic [supervisor_pkg::TIMER_W-1:0] ONE_C     = supervisor_pkg::TIMER_W'(1);

  logic [supervisor_pkg::TIMER_W-1:0] cnt_q;

  // ==========================================================================
  // Stretch counter
  // ==========================================================================
  // The first tick after release may come at once, so one extra tick is
  // counted to keep the stretch at or above its least length.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q            <= '0;
      reset_active_out <= 1'b1;
    end else if (hold_in) begin
      cnt_q            <= '0;
      reset_active_out <= 1'b1;
    end else if (reset_active_out && tick_in) begin
      if (cnt_q == STRETCH_C) begin
        reset_active_out <= 1'b0;
      end else begin
        cnt_q <= cnt_q + ONE_C;
      end
    end
  end

endmodule : reset_stretcher

/* File: verif/supervisor_props.sv */
// Port-level checks of the windowed watchdog reset supervisor.
`timescale 1ns/1ps
module supervisor_props #(
  parameter int unsigned RESET_STRETCH_TICKS = supervisor_pkg::RESET_STRETCH_TICKS,
  parameter int unsigned EARLY_LIMIT_TICKS   = supervisor_pkg::EARLY_LIMIT_TICKS,
  parameter int unsigned LATE_LIMIT_TICKS    = supervisor_pkg::LATE_LIMIT_TICKS,
  parameter int unsigned FAULT_PULSE_TICKS   = supervisor_pkg::FAULT_PULSE_TICKS
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic operator_reset_n_in,
  input wire logic supply_good_in,
  input wire logic kick_input_in,
  input wire logic reset_n_out,
  input wire logic fault_pulse_out,
  input wire logic fault_pulse_oe_out,
  input wire logic fast_fault_out,
  input wire logic slow_fault_out
);
  localparam int T = supervisor_pkg::TICK_CYCLES;
  int   op_low_q;
  int   sup_q;
  int   ok_q;
  int   oe_q;
  int   win_q;
  logic kick_q;

  // ==========================================================================
  // Helper counters
  // ==========================================================================
  // The window count restarts at the raw kick fall, ahead of the filtered one, so bounds carry slack.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_low_q <= 0;
      sup_q    <= 0;
      ok_q     <= 0;
      oe_q     <= 0;
      win_q    <= 0;
      kick_q   <= 1'b0;
    end else begin
      op_low_q <= operator_reset_n_in ? 0 : op_low_q + 1;
      sup_q    <= supply_good_in ? sup_q + 1 : 0;
      ok_q     <= (operator_reset_n_in && supply_good_in) ? ok_q + 1 : 0;
      oe_q     <= fault_pulse_oe_out ? oe_q + 1 : 0;
      kick_q   <= kick_input_in;
      win_q    <= (!reset_n_out || fault_pulse_oe_out || (kick_q && !kick_input_in)) ? 0 : win_q + 1;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_oe_needs_reset: assert property (fault_pulse_oe_out |-> reset_n_out)
    else $error("fault pulse active during reset");
  a_oper_forces_reset: assert property (op_low_q >= 20 |-> !reset_n_out && !fault_pulse_oe_out)
    else $error("operator low did not force reset");
  a_reset_fall_cause: assert property ($fell(reset_n_out) |-> op_low_q >= 13 || sup_q < 8)
    else $error("reset fell without a cause");
  a_stretch_min: assert property ($rose(reset_n_out) |-> ok_q >= RESET_STRETCH_TICKS * T)
    else $error("reset released too soon");
  a_pulse_length: assert property (
      $fell(fault_pulse_oe_out) && ok_q > 40 |->
      oe_q >= (FAULT_PULSE_TICKS - 1) * T && oe_q <= FAULT_PULSE_TICKS * T + 2)
    else $error("fault pulse width wrong");
  a_fault_starts_pulse: assert property (
      fast_fault_out || slow_fault_out |=> fault_pulse_oe_out && !fault_pulse_out)
    else $error("fault did not start a pulse");
  a_quiet_in_reset: assert property (!reset_n_out |-> !fast_fault_out && !slow_fault_out)
    else $error("fault reported during reset");
  a_quiet_in_pulse: assert property (fault_pulse_oe_out |-> !fast_fault_out && !slow_fault_out)
    else $error("fault reported during pulse");
  a_fault_no_reset: assert property ($rose(fault_pulse_oe_out) |-> reset_n_out [*8])
    else $error("fault pulse pulled reset");
  a_slow_timing: assert property (
      slow_fault_out |-> win_q >= (LATE_LIMIT_TICKS - 1) * T - 8 && win_q <= LATE_LIMIT_TICKS * T + 80)
    else $error("slow fault at wrong time");
endmodule : supervisor_props

bind windowed_watchdog_reset_supervisor supervisor_props #(
  .RESET_STRETCH_TICKS(RESET_STRETCH_TICKS),
  .EARLY_LIMIT_TICKS(EARLY_LIMIT_TICKS),
  .LATE_LIMIT_TICKS(LATE_LIMIT_TICKS),
  .FAULT_PULSE_TICKS(FAULT_PULSE_TICKS)
) supervisor_props_inst (.core_clk_in, .rst_in, .operator_reset_n_in, .supply_good_in, .kick_input_in,
  .reset_n_out, .fault_pulse_out, .fault_pulse_oe_out, .fast_fault_out, .slow_fault_out);

/* File: verif/kick_model.sv */
// Processor side that toggles the kick line on command.
`timescale 1ns/1ps
module kick_model #(
  parameter int HIGH_CYCLES = 48
) (
  // Clock and command
  input  wire logic core_clk_in,
  input  wire logic go_in,
  // Kick line
  output logic      kick_out
);
  int left_q = 0;

  // ==========================================================================
  // Pulse shaping
  // ==========================================================================
  // wide kick pulses
  // High then low, each well past the minimum width; callers space commands so the low also lasts.
  always @(posedge core_clk_in) begin
    if (go_in) begin
      left_q <= HIGH_CYCLES;
    end else if (left_q != 0) begin
      left_q <= left_q - 1;
    end
  end
  assign kick_out = (left_q != 0);
endmodule : kick_model

/* File: verif/testbench.sv */
// Self-checking bench for the windowed watchdog reset supervisor.
`timescale 1ns/1ps
module testbench;
  localparam int T = supervisor_pkg::TICK_CYCLES;
  logic core_clk_in         = 1'b0;
  logic rst_in              = 1'b1;
  logic operator_reset_n_in = 1'b1;
  logic supply_good_in      = 1'b1;
  logic go                  = 1'b0;
  logic kick_input_in;
  logic reset_n_out;
  logic fault_pulse_out;
  logic fault_pulse_oe_out;
  logic fast_fault_out;
  logic slow_fault_out;
  int   fails = 0;
  int   total_checks = 0;
  int   n_fast = 0;
  int   n_slow = 0;
  int   n;

  always #4 core_clk_in = ~core_clk_in;

  // Short counts keep the run brief; every expectation below is derived from them.
  windowed_watchdog_reset_supervisor #(.RESET_STRETCH_TICKS(20), .EARLY_LIMIT_TICKS(5), .LATE_LIMIT_TICKS(20),
    .FAULT_PULSE_TICKS(4)) windowed_watchdog_reset_supervisor_inst (.core_clk_in, .rst_in, .operator_reset_n_in,
    .supply_good_in, .kick_input_in, .reset_n_out, .fault_pulse_out, .fault_pulse_oe_out, .fast_fault_out,
    .slow_fault_out);
  kick_model kick_model_inst (.core_clk_in, .go_in(go), .kick_out(kick_input_in));

  always @(posedge core_clk_in) begin
    if (fast_fault_out === 1'b1) n_fast++;
    if (slow_fault_out === 1'b1) n_slow++;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk_in);
  endtask : cyc

  task automatic kick();
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask : kick

  function automatic logic pick(input int s);
    case (s)
      0: return reset_n_out;
      1: return fault_pulse_oe_out;
      default: return slow_fault_out;
    endcase
  endfunction : pick

  task automatic wait_for(input int s, input logic v, input int lim, output int took);
    took = 0;
    while (pick(s) !== v && took < lim) begin
      cyc(1);
      took++;
    end
    if (took >= lim) begin
      fails++;
      $display("BAD %0t: wait ran out", $time);
    end
  endtask : wait_for

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_power_up();
    cyc(20 * T);
    chk(reset_n_out, 1'b0);
    wait_for(0, 1'b1, 3 * T, n);
  endtask : t_power_up

  task automatic t_normal();
    kick();
    repeat (3) begin
      cyc(10 * T);
      kick();
    end
    cyc(T);
    chk(n_fast, 0);
    chk(n_slow, 0);
  endtask : t_normal

  task automatic t_fast();
    cyc(8 * T);
    kick();
    cyc(2 * T);
    kick();
    wait_for(1, 1'b1, T, n);
    chk(n_fast, 1);
    chk(fault_pulse_out, 1'b0);
    kick();
    wait_for(1, 1'b0, 6 * T, n);
    chk(n >= 3 * T - 2 && n <= 4 * T + 2, 1'b1);
    chk(reset_n_out, 1'b1);
    kick();
    cyc(6 * T);
    kick();
    cyc(T);
    chk(n_fast, 1);
  endtask : t_fast

  task automatic t_slow();
    wait_for(2, 1'b1, 25 * T, n);
    // The report stands one cycle; the pulse and the count follow an edge later.
    cyc(1);
    chk(n_slow, 1);
    wait_for(1, 1'b0, 6 * T, n);
    wait_for(2, 1'b1, 25 * T, n);
    chk(n >= 19 * T - 8 && n <= 20 * T + 8, 1'b1);
    cyc(5);
    operator_reset_n_in = 1'b0;
    cyc(30);
    chk(fault_pulse_oe_out, 1'b0);
    chk(reset_n_out, 1'b0);
    cyc(200);
    operator_reset_n_in = 1'b1;
    cyc(20 * T);
    chk(reset_n_out, 1'b0);
    wait_for(0, 1'b1, 3 * T, n);
    wait_for(2, 1'b1, 25 * T, n);
    chk(n >= 19 * T - 8 && n <= 20 * T + 8, 1'b1);
    cyc(1);
    wait_for(1, 1'b0, 6 * T, n);
  endtask : t_slow

  task automatic t_glitch();
    operator_reset_n_in = 1'b0;
    cyc(12);
    operator_reset_n_in = 1'b1;
    cyc(40);
    chk(reset_n_out, 1'b1);
  endtask : t_glitch

  task automatic t_supply();
    supply_good_in = 1'b0;
    cyc(10);
    chk(reset_n_out, 1'b0);
    kick();
    cyc(100);
    kick();
    cyc(100);
    chk(n_fast, 1);
    chk(fault_pulse_oe_out, 1'b0);
    chk(n_slow, 3);
    supply_good_in = 1'b1;
    wait_for(0, 1'b1, 25 * T, n);
  endtask : t_supply

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    cyc(6);
    rst_in = 1'b0;
    t_power_up();
    t_normal();
    t_fast();
    t_slow();
    t_glitch();
    t_supply();
    conclude();
  end

  // A hang costs at most this many cycles; the full sequence needs about three fifths of it.
  initial begin
    repeat (300 * T) @(posedge core_clk_in);
    fails++;
    conclude();
  end
endmodule : testbench
